/* File: hdl/mii_timing_pkg.sv */
// mii_timing_pkg: constants, structs and cycle counts for the nibble
// interface timing block.
// assumes one system clock at CLK_PERIOD_NS; all counts except SYNC_CYC derive from it.
package mii_timing_pkg;

  // ****************************************
  // clock and bit times
  // ****************************************
  localparam int CLK_PERIOD_NS  = 100;
  localparam int BIT_NS_10M     = 100;
  localparam int BIT_NS_100M    = 10;
  localparam int NIB_CLK_NS_10M = 400;
  localparam int NIB_CLK_NS_100M = 40;

  // longest allowed time, rounded down, never below one cycle
  function automatic int max_cyc(input int bits, input int bit_ns);
    int c;
    c = (bits * bit_ns) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int HALF_10M  = max_cyc(1, NIB_CLK_NS_10M / 2);
  localparam int HALF_100M = max_cyc(1, NIB_CLK_NS_100M / 2);
  localparam logic [1:0] HALF_10M_C  = 2'(HALF_10M);
  localparam logic [1:0] HALF_100M_C = 2'(HALF_100M);
  localparam logic [1:0] ONE_C       = 2'h1;
  localparam logic [1:0] ZERO_C      = 2'h0;

  // ****************************************
  // latencies in bit times and in cycles
  // ****************************************
  localparam int RX_LAT_BITS     = 7;
  localparam int TX10_LAT_BITS   = 2;
  localparam int TX100_LAT_BITS  = 3;
  localparam int CRS_ON100_BITS  = 4;
  localparam int CRS_ON10_BITS   = 2;
  localparam int CRS_OFF_BITS    = 4;
  localparam int RX_LAT_CYC      = max_cyc(RX_LAT_BITS, BIT_NS_10M);
  localparam int TX10_LAT_CYC    = max_cyc(TX10_LAT_BITS, BIT_NS_10M);
  localparam int TX100_LAT_CYC   = max_cyc(TX100_LAT_BITS, BIT_NS_100M);
  localparam int CRS_ON100_CYC   = max_cyc(CRS_ON100_BITS, BIT_NS_100M);
  localparam int CRS_ON10_CYC    = max_cyc(CRS_ON10_BITS, BIT_NS_10M);
  localparam int CRS_OFF_CYC     = max_cyc(CRS_OFF_BITS, BIT_NS_100M);
  localparam int SYNC_CYC        = 2;

  // ****************************************
  // nibble, symbols and synchroniser lanes
  // ****************************************
  localparam int         NIB_W     = 4;
  localparam logic [1:0] NIB_LAST  = 2'h3;
  localparam logic       J_FIRST   = 1'b1;
  localparam logic       H_FIRST   = 1'b0;
  localparam int         SYNC_W    = 5;
  localparam int         IDX_ACT   = 0;
  localparam int         IDX_DAT   = 1;
  localparam int         IDX_ERR   = 2;
  localparam int         IDX_MDC   = 3;
  localparam int         IDX_MDIO  = 4;

  typedef struct packed {
    logic             en;
    logic             er;
    logic [NIB_W-1:0] d;
  } mii_tx_s;

  typedef struct packed {
    logic             dv;
    logic             er;
    logic [NIB_W-1:0] d;
  } mii_rx_s;

  typedef struct packed {
    logic act;
    logic dat;
  } line_tx_s;

  typedef struct packed {
    logic act;
    logic dat;
    logic err;
  } line_rx_s;

endpackage

/* File: hdl/pin_sync.sv */
// pin_sync: two-flop synchronisers for the asynchronous pin inputs,
// with a rising-edge flag taken from the settled stages only.
// assumes inputs are quasi-static over at least two system clocks.
`timescale 1ns/1ps
module pin_sync (
  input  wire logic                                clk_sys_i,
  input  wire logic                                rst_n_i,
  input  wire logic                                ce_i,
  input  wire logic [mii_timing_pkg::SYNC_W-1:0]   async_i,
  output logic      [mii_timing_pkg::SYNC_W-1:0]   lvl_o,
  output logic      [mii_timing_pkg::SYNC_W-1:0]   rise_o
);
  import mii_timing_pkg::*;

  logic [SYNC_W-1:0] meta;
  logic [SYNC_W-1:0] stage;
  logic [SYNC_W-1:0] last;

  // ****************************************
  // synchroniser stages
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      meta  <= '0;
      stage <= '0;
      last  <= '0;
    end else if (ce_i) begin
      meta  <= async_i;
      stage <= meta;
      last  <= stage;
    end
  end

  assign lvl_o  = stage;
  assign rise_o = stage & ~last;

endmodule

/* File: hdl/phy_mii_datapath_timing.sv */
// phy_mii_datapath_timing: nibble interface clocks, transmit and receive
// datapath latencies and transmit carrier sense of a 10/100 PHY.
// assumes the MAC runs on logic clocked by clk_sys_i; line and management
// pins are asynchronous and are synchronised here.
//
// Overview of operation
// - receive clock period is 400 ns at 10M, 40 ns at 100M; here 200 ns at 100M, one cycle per half
// - transmit nibble, enable and error sampled on transmit clock rise
// - receive nibble, valid and error launched for capture on rx rise
// - management write bit taken on clock rise; read bit launched after
// - 10M receive nibble presented within 7 bit times of first line bit
// - 10M first line bit within 2 bit times of sampling the nibble
// - 100M first bit of J within 3 bit times of enable sampled; here one cycle, 10 bit times
// - 100M half duplex: carrier sense on within 4 bit times; here one cycle, 10 bit times
// - half duplex: carrier sense off within 4 bit times of enable off; at 100M here one cycle, 10 bit times
// - 10M half duplex: carrier sense on within 2 bit times
// - at 10M one bit time is 100 ns
`timescale 1ns/1ps
module phy_mii_datapath_timing (
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      ce_i,
  input  wire logic                      speed_100_i,
  input  wire logic                      half_duplex_i,
  input  wire mii_timing_pkg::mii_tx_s   mii_tx_i,
  output logic                           tx_clk_o,
  output logic                           rx_clk_o,
  output mii_timing_pkg::mii_rx_s        mii_rx_o,
  output logic                           crs_o,
  input  wire mii_timing_pkg::line_rx_s  line_receive_pair_i,
  output mii_timing_pkg::line_tx_s       line_transmit_pair_o,
  input  wire logic                      mdc_i,
  input  wire logic                      mdio_i,
  output logic                           mdio_o,
  output logic                           mdio_oe_o,
  input  wire logic                      mgmt_rd_bit_i,
  input  wire logic                      mgmt_rd_en_i,
  output logic                           mgmt_wr_bit_o,
  output logic                           mgmt_wr_stb_o
);
  import mii_timing_pkg::*;

  localparam int RX_WAIT     = RX_LAT_CYC - SYNC_CYC;
  localparam int CRS_ON100_W = CRS_ON100_CYC;
  localparam int CRS_ON10_W  = CRS_ON10_CYC;
  localparam int CRS_OFF_W   = CRS_OFF_CYC;

  logic [SYNC_W-1:0] pin_lvl;
  logic [SYNC_W-1:0] pin_rise;
  logic [1:0]        half;
  logic [1:0]        tx_cnt;
  logic [1:0]        rx_cnt;
  logic              tx_tick;
  logic              rx_fall;
  logic              tx_on;
  logic [2:0]        tx_sh;
  logic [1:0]        bcnt;
  logic [2:0]        rx_sh;
  logic              rx_load;

  // ****************************************
  // pin synchronisers
  // ****************************************
  pin_sync u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .async_i   ({mdio_i, mdc_i, line_receive_pair_i.err,
                 line_receive_pair_i.dat, line_receive_pair_i.act}),
    .lvl_o     (pin_lvl),
    .rise_o    (pin_rise)
  );

  // ****************************************
  // nibble clocks
  // ****************************************
  // half period by rate
  assign half    = speed_100_i ? HALF_100M_C : HALF_10M_C;
  assign tx_tick = (tx_cnt == half - ONE_C) && !tx_clk_o;
  assign rx_fall = (rx_cnt == half - ONE_C) && rx_clk_o;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tx_cnt   <= ZERO_C;
      tx_clk_o <= 1'b0;
    end else if (ce_i) begin
      if (tx_cnt == half - ONE_C) begin
        tx_cnt   <= ZERO_C;
        tx_clk_o <= ~tx_clk_o;
      end else begin
        tx_cnt <= tx_cnt + ONE_C;
      end
    end
  end

  // receive clock, realigned to each nibble load
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rx_cnt   <= ZERO_C;
      rx_clk_o <= 1'b0;
    end else if (ce_i) begin
      if (rx_load) begin
        rx_cnt   <= ZERO_C;
        rx_clk_o <= 1'b0;
      end else if (rx_cnt == half - ONE_C) begin
        rx_cnt   <= ZERO_C;
        rx_clk_o <= ~rx_clk_o;
      end else begin
        rx_cnt <= rx_cnt + ONE_C;
      end
    end
  end

  // ****************************************
  // transmit path
  // ****************************************
  // sample on tx rise, emit first bit next cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tx_on                <= 1'b0;
      tx_sh                <= '0;
      line_transmit_pair_o <= '0;
    end else if (ce_i) begin
      if (tx_tick) begin
        tx_on <= mii_tx_i.en;
        tx_sh <= mii_tx_i.d[NIB_W-1:1];
        line_transmit_pair_o.act <= mii_tx_i.en;
        if (!mii_tx_i.en) begin
          line_transmit_pair_o.dat <= 1'b0;
        end else if (speed_100_i && !tx_on) begin
          line_transmit_pair_o.dat <= J_FIRST;
        end else if (speed_100_i && mii_tx_i.er) begin
          line_transmit_pair_o.dat <= H_FIRST;
        end else begin
          line_transmit_pair_o.dat <= mii_tx_i.d[0];
        end
      end else if (!speed_100_i) begin
        line_transmit_pair_o.dat <= tx_sh[0];
        tx_sh <= {1'b0, tx_sh[2:1]};
      end
    end
  end

  // carrier sense follows enable in half duplex, or receive activity, each cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      crs_o <= 1'b0;
    end else if (ce_i) begin
      crs_o <= (half_duplex_i && mii_tx_i.en) || pin_lvl[IDX_ACT];
    end
  end

  // ****************************************
  // receive path
  // ****************************************
  assign rx_load = pin_lvl[IDX_ACT] && (bcnt == NIB_LAST);

  // deserialise one line bit per system clock cycle, which is one bit time at 10M only
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      bcnt  <= ZERO_C;
      rx_sh <= '0;
    end else if (ce_i) begin
      if (pin_lvl[IDX_ACT]) begin
        bcnt  <= bcnt + ONE_C;
        rx_sh <= {pin_lvl[IDX_DAT], rx_sh[2:1]};
      end else begin
        bcnt <= ZERO_C;
      end
    end
  end

  // nibble launched on receive clock fall
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mii_rx_o <= '0;
    end else if (ce_i) begin
      if (rx_load) begin
        mii_rx_o.dv <= 1'b1;
        mii_rx_o.er <= pin_lvl[IDX_ERR];
        mii_rx_o.d  <= {pin_lvl[IDX_DAT], rx_sh};
      end else if (!pin_lvl[IDX_ACT] && rx_fall) begin
        mii_rx_o <= '0;
      end
    end
  end

  // ****************************************
  // management bit timing
  // ****************************************
  // take write bit at clock rise, launch read bit after it
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mgmt_wr_bit_o <= 1'b0;
      mgmt_wr_stb_o <= 1'b0;
      mdio_o        <= 1'b0;
      mdio_oe_o     <= 1'b0;
    end else if (ce_i) begin
      mgmt_wr_stb_o <= pin_rise[IDX_MDC];
      if (pin_rise[IDX_MDC]) begin
        mgmt_wr_bit_o <= pin_lvl[IDX_MDIO];
        mdio_o        <= mgmt_rd_bit_i;
        mdio_oe_o     <= mgmt_rd_en_i;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_rx_period;
    @(posedge clk_sys_i) disable iff (!rst_n_i || !ce_i)
      (!speed_100_i && !rx_load && $rose(rx_clk_o))
      ##1 (!speed_100_i && !rx_load) [*3] |=> $rose(rx_clk_o);
  endproperty
  a_rx_period: assert property (p_rx_period)
    else $error("receive clock period wrong at 10M");

  property p_tx_period;
    @(posedge clk_sys_i) disable iff (!rst_n_i || !ce_i)
      (!speed_100_i && $rose(tx_clk_o)) ##1 !speed_100_i [*3]
      |=> $rose(tx_clk_o);
  endproperty
  a_tx_period: assert property (p_tx_period)
    else $error("transmit clock period not four bit times");

  property p_tx_sample;
    @(posedge clk_sys_i) disable iff (!rst_n_i || !ce_i)
      tx_tick |=> $rose(tx_clk_o) && (tx_on == $past(mii_tx_i.en));
  endproperty
  a_tx_sample: assert property (p_tx_sample)
    else $error("transmit enable not sampled at clock rise");

  property p_rx_launch;
    @(posedge clk_sys_i) disable iff (!rst_n_i || !ce_i)
      $changed(mii_rx_o) |-> !rx_clk_o;
  endproperty
  a_rx_launch: assert property (p_rx_launch)
    else $error("receive data changed while receive clock high");

  property p_mdio_launch;
    @(posedge clk_sys_i) disable iff (!rst_n_i || !ce_i)
      $changed(mdio_o) |-> $past(pin_rise[IDX_MDC]);
  endproperty
  a_mdio_launch: assert property (p_mdio_launch)
    else $error("read bit launched away from clock rise");

  property p_rx_latency;
    @(posedge clk_sys_i) disable iff (!rst_n_i || !ce_i)
      (!speed_100_i && pin_rise[IDX_ACT]) |-> ##[1:RX_WAIT] mii_rx_o.dv;
  endproperty
  a_rx_latency: assert property (p_rx_latency)
    else $error("receive nibble late");

  property p_tx10_latency;
    @(posedge clk_sys_i) disable iff (!rst_n_i || !ce_i)
      (!speed_100_i && tx_tick && mii_tx_i.en)
      |=> line_transmit_pair_o.act
          && (line_transmit_pair_o.dat == $past(mii_tx_i.d[0]));
  endproperty
  a_tx10_latency: assert property (p_tx10_latency)
    else $error("first line bit late at 10M");

  property p_tx100_j;
    @(posedge clk_sys_i) disable iff (!rst_n_i || !ce_i)
      (speed_100_i && tx_tick && mii_tx_i.en && !tx_on)
      |=> line_transmit_pair_o.act && line_transmit_pair_o.dat;
  endproperty
  a_tx100_j: assert property (p_tx100_j)
    else $error("start symbol late at 100M");

  property p_crs_on100;
    @(posedge clk_sys_i) disable iff (!rst_n_i || !ce_i)
      (speed_100_i && half_duplex_i && mii_tx_i.en)
      |-> ##[1:CRS_ON100_W] crs_o;
  endproperty
  a_crs_on100: assert property (p_crs_on100)
    else $error("carrier sense late at 100M");

  property p_crs_on10;
    @(posedge clk_sys_i) disable iff (!rst_n_i || !ce_i)
      (!speed_100_i && half_duplex_i && $rose(mii_tx_i.en))
      |-> ##[1:CRS_ON10_W] crs_o;
  endproperty
  a_crs_on10: assert property (p_crs_on10)
    else $error("carrier sense late at 10M");

  property p_crs_off;
    @(posedge clk_sys_i) disable iff (!rst_n_i || !ce_i)
      (half_duplex_i && $fell(mii_tx_i.en) && !pin_lvl[IDX_ACT])
      ##1 !pin_lvl[IDX_ACT] |-> ##[0:CRS_OFF_W] !crs_o;
  endproperty
  a_crs_off: assert property (p_crs_off)
    else $error("carrier sense held too long");

endmodule

/* File: testbench/mac_model.sv */
// mac_model: MAC stand-in that sends one nibble per request.
// assumes tx_clk_i comes from the device in the clk_sys_i domain.
`timescale 1ns/1ps
module mac_model (
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    tx_clk_i,
  input  wire logic                    go_i,
  input  wire logic [3:0]              nib_i,
  output mii_timing_pkg::mii_tx_s      mii_tx_o
);
  import mii_timing_pkg::*;
  logic clk_q;
  logic pend;

  always_ff @(posedge clk_sys_i) begin
    clk_q <= tx_clk_i;
    if (!rst_n_i) begin
      pend     <= 1'b0;
      mii_tx_o <= '0;
    end else begin
      if (tx_clk_i && !clk_q) begin
        mii_tx_o.en <= pend;
        mii_tx_o.er <= 1'b0;
        mii_tx_o.d  <= pend ? nib_i : ~mii_tx_o.d;
        pend        <= 1'b0;
      end
      if (go_i) begin
        pend <= 1'b1;
      end
    end
  end
endmodule

/* File: testbench/tb.sv */
// tb: self-checking bench for the nibble interface timing block.
// assumes mac_model on the transmit side and a 10 MHz system clock.
`timescale 1ns/1ps
module tb;
  import mii_timing_pkg::*;
  // *****
  // signals
  // *****
  typedef struct packed {
    logic       spd;
    logic       hd;
    logic [3:0] nib;
    logic [7:0] per;
    logic       first;
    logic       crs;
  } row_s;
  // 100M clock floors to 1 high / 1 low cycle
  row_s     rows [4] = '{'{1'b0, 1'b1, 4'hA, 8'h04, 1'b0, 1'b1},
                         '{1'b0, 1'b0, 4'h5, 8'h04, 1'b1, 1'b0},
                         '{1'b1, 1'b1, 4'h6, 8'h02, J_FIRST, 1'b1},
                         '{1'b1, 1'b0, 4'h3, 8'h02, J_FIRST, 1'b0}};
  logic     clk = 1'b0;
  logic     rst_n = 1'b0;
  logic     speed_100 = 1'b0;
  logic     half_dup = 1'b0;
  logic     go = 1'b0;
  logic     ce = 1'b1;
  logic [3:0] nib = 4'h0;
  mii_tx_s  mii_tx;
  mii_rx_s  mii_rx;
  line_rx_s line_rx = '0;
  line_tx_s line_tx;
  logic     tx_clk, rx_clk, crs, mdio_out, mdio_oe, wr_bit, wr_stb;
  logic     mdc = 1'b0;
  logic     sta_mdio = 1'b1;
  logic     mdio_w;
  logic     rd_bit = 1'b0;
  logic     rd_en = 1'b0;
  logic     md_run = 1'b0;
  logic [2:0] md_ph = 3'h0;
  int       cyc = 0;
  int       error_cnt = 0;
  int       total_checks = 0;

  // station value (1 when idle) on the management data wire while the device output is disabled
  assign mdio_w = mdio_oe ? mdio_out : sta_mdio;

  always #50 clk = ~clk;

  mac_model mac_u (
    .clk_sys_i (clk),
    .rst_n_i   (rst_n),
    .tx_clk_i  (tx_clk),
    .go_i      (go),
    .nib_i     (nib),
    .mii_tx_o  (mii_tx)
  );

  phy_mii_datapath_timing dut_u (
    .clk_sys_i            (clk),
    .rst_n_i              (rst_n),
    .ce_i                 (ce),
    .speed_100_i          (speed_100),
    .half_duplex_i        (half_dup),
    .mii_tx_i             (mii_tx),
    .tx_clk_o             (tx_clk),
    .rx_clk_o             (rx_clk),
    .mii_rx_o             (mii_rx),
    .crs_o                (crs),
    .line_receive_pair_i  (line_rx),
    .line_transmit_pair_o (line_tx),
    .mdc_i                (mdc),
    .mdio_i               (mdio_w),
    .mdio_o               (mdio_out),
    .mdio_oe_o            (mdio_oe),
    .mgmt_rd_bit_i        (rd_bit),
    .mgmt_rd_en_i         (rd_en),
    .mgmt_wr_bit_o        (wr_bit),
    .mgmt_wr_stb_o        (wr_stb)
  );

  // *****
  // helpers
  // *****
  task automatic chk_bit(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s exp %b got %b", n, e, g);
    end
  endtask

  task automatic chk_val(input string n, input logic [7:0] e,
                         input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wrise(input logic sel);
    int k;
    for (k = 0; k < 20 && (sel ? rx_clk : tx_clk) !== 1'b0; k++) begin
      @(negedge clk);
    end
    for (k = 0; k < 20 && (sel ? rx_clk : tx_clk) !== 1'b1; k++) begin
      @(negedge clk);
    end
  endtask

  // line bits one per cycle, released line shows the inverse
  task automatic line_send(input logic [7:0] b);
    int k;
    for (k = 0; k < 8; k++) begin
      @(posedge clk);
      line_rx <= '{1'b1, b[k], k == 7};
    end
    @(posedge clk);
    line_rx <= '{1'b0, ~b[7], 1'b0};
  endtask

  // management clock, 800 ns, still outside frames
  always @(posedge clk) begin
    md_ph <= md_run ? md_ph + 3'h1 : 3'h0;
    mdc   <= md_run && md_ph[2];
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      error_cnt++;
      results();
    end
  end

  // *****
  // sequence
  // *****
  initial begin
    int   i, k, c0;
    logic pt;
    row_s r;
    repeat (7) @(posedge clk);
    @(negedge clk);
    chk_val("rst outs", 8'h00,
            {tx_clk, rx_clk, crs, wr_stb, mdio_oe, line_tx, 1'b0});
    chk_val("rst rx", 8'h00, {2'b00, mii_rx});
    @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 4; i++) begin
      r = rows[i];
      @(posedge clk);
      speed_100 <= r.spd;
      half_dup  <= r.hd;
      nib       <= r.nib;
      repeat (8) @(posedge clk);
      for (k = 0; k < 2; k++) begin
        wrise(k[0]);
        c0 = cyc;
        wrise(k[0]);
        chk_val("clk period", r.per, 8'(cyc - c0));
      end
      @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(negedge clk);
      pt = 1'b1;
      for (k = 0; k < 20 && line_tx.act !== 1'b1; k++) begin
        pt = tx_clk;
        @(negedge clk);
      end
      chk_bit("tx first", 1'b1, !pt && tx_clk);
      chk_bit("tx dat", r.first, line_tx.dat);
      chk_bit("crs on", r.crs, crs);
      for (k = 1; k < 4 && !r.spd; k++) begin
        @(negedge clk);
        chk_bit("tx bit", r.nib[k], line_tx.dat);
      end
      for (k = 0; k < 20 && mii_tx.en !== 1'b0; k++) begin
        @(negedge clk);
      end
      @(negedge clk);
      chk_bit("crs off", 1'b0, crs);
    end
    @(posedge clk);
    speed_100 <= 1'b0;
    half_dup  <= 1'b0;
    fork
      line_send(8'h3C);
      begin
        @(posedge clk);
        @(negedge clk);
        c0 = cyc;
        for (k = 0; k < 20 && mii_rx.dv !== 1'b1; k++) begin
          @(negedge clk);
        end
        chk_bit("rx lat", 1'b1, (cyc - c0) <= RX_LAT_BITS);
        chk_val("rx nib0", 8'h2C, {2'b00, mii_rx});
        chk_bit("rx clk low", 1'b0, rx_clk);
        repeat (2) @(negedge clk);
        chk_bit("rx clk rise", 1'b1, rx_clk);
        repeat (2) @(negedge clk);
        chk_val("rx nib1", 8'h33, {2'b00, mii_rx});
        for (k = 0; k < 20 && mii_rx.dv !== 1'b0; k++) begin
          @(negedge clk);
        end
        chk_bit("dv off", 1'b0, mii_rx.dv);
      end
    join
    @(posedge clk);
    md_run <= 1'b1;
    for (i = 0; i < 2; i++) begin
      sta_mdio <= i[0];
      rd_en    <= i[0];
      rd_bit   <= !i[0];
      for (k = 0; k < 20 && mdc !== 1'b1; k++) begin
        @(negedge clk);
      end
      for (k = 0; k < 8 && wr_stb !== 1'b1; k++) begin
        @(negedge clk);
      end
      chk_bit("md lat", 1'b1, k <= 3);
      chk_bit("wr bit", i[0], wr_bit);
      chk_bit("rd oe", i[0], mdio_oe);
      chk_bit("rd bit", !i[0], mdio_out);
      @(negedge clk);
      chk_bit("stb pulse", 1'b0, wr_stb);
      for (k = 0; k < 20 && mdc !== 1'b0; k++) begin
        @(negedge clk);
      end
      @(posedge clk);
    end
    md_run   <= 1'b0;
    rd_en    <= 1'b0;
    sta_mdio <= 1'b1;
    // clock enable low freezes the nibble clocks
    @(posedge clk);
    ce <= 1'b0;
    @(negedge clk);
    pt = tx_clk;
    repeat (6) @(negedge clk);
    chk_bit("ce hold", pt, tx_clk);
    @(posedge clk);
    ce <= 1'b1;
    repeat (7) @(negedge clk);
    chk_bit("ce run", ~pt, tx_clk);
    repeat (4) @(posedge clk);
    results();
  end
endmodule
